// >>> design/odt_sync_ctrl.sv
// What this block does
// - Termination follows synchronous timing while the DLL is on and locked, except in self-refresh and slow-exit power-down.
// - Termination turns on and off the set latency after ODT is sampled.
// - Turn-on and turn-off latency equal CAS write plus additive latency, less two.
// - The internal ODT signal is delayed by the additive latency.
// - Termination is on only while the device is not driving the data bus.
// - Dynamic strength switching is enabled when either write-termination bit is set.
// - Nominal strength comes from MR1 A9,A6,A2; write strength from MR2 A10,A9.
// - Without writes, nominal strength applies and the ODT pin sets on/off timing.
// - A registered write selects write strength write latency minus two clocks later.
// - Nominal strength returns four (chop) or six (BL8) clocks after the switch.
// - Turn-off and strength switches lag half a memory clock.
// - With all termination bits zero the ODT pin is ignored.
// - Termination stays off and ODT is ignored during self-refresh.
`timescale 1ns/1ps
`default_nettype none

module odt_sync_ctrl #(
    parameter int DEPTH = odt_ctrl_pkg::LINE_DEPTH
) (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    // Memory interface pins, asynchronous to the system clock
    input  wire logic       i_ck,
    input  wire logic       i_odt,
    input  wire logic       i_cke,
    input  wire logic       i_cs_n,
    input  wire logic       i_ras_n,
    input  wire logic       i_cas_n,
    input  wire logic       i_we_n,
    input  wire logic       i_a12,
    // Mode register fields
    input  wire logic [3:0] i_cas_write_lat,
    input  wire logic [3:0] i_additive_lat,
    input  wire logic [2:0] i_rtt_nom_bits,
    input  wire logic [1:0] i_rtt_wr_bits,
    input  wire logic [1:0] i_burst_mode,
    input  wire logic       i_mr0_dll_pd_keep,
    // Device state
    input  wire logic       i_dll_locked,
    input  wire logic       i_dll_off_mode,
    input  wire logic       i_self_refresh,
    input  wire logic       i_any_bank_open,
    input  wire logic       i_dq_driving,
    // Termination control
    output logic            o_term_en,
    output logic            o_term_is_write,
    output logic [2:0]      o_term_code,
    output logic            o_sync_mode
);

    localparam int IDX_W = $clog2(DEPTH);
    localparam int HALF  = odt_ctrl_pkg::HALF_CK_CYCLES;

    initial begin
        if (DEPTH < 29 || DEPTH > 32) $error("delay line depth must cover write latency 28");
        if (HALF < 2 || HALF > 8) $error("half memory clock must be two to eight system cycles");
    end

    logic [odt_ctrl_pkg::PIN_COUNT-1:0] pins_s;
    logic                               ck_q;
    logic                               ck_rise;
    logic                               ck_rise_q;
    logic                               odt_mode_en;
    logic                               dynamic_en;
    logic                               active;
    logic [4:0]                         write_lat;
    logic [IDX_W-1:0]                   term_lat;
    logic                               odt_in;
    logic [1:0]                         wr_in;
    logic                               odt_tap;
    logic [1:0]                         wr_tap;
    logic                               term_on;
    logic [2:0]                         off_cnt;
    logic                               wr_win;
    logic [2:0]                         wr_left;
    logic [2:0]                         sw_cnt;

    function automatic logic is_write_cmd(input logic [3:0] cmd);
        return cmd == odt_ctrl_pkg::CMD_WRITE;
    endfunction : is_write_cmd

    function automatic logic burst_is_bl8(input logic [1:0] mode, input logic a12);
        case (mode)
            odt_ctrl_pkg::BL_FIXED_8: return 1'b1;
            odt_ctrl_pkg::BL_OTF:     return a12;
            default:                  return 1'b0;
        endcase
    endfunction : burst_is_bl8

    pin_sync #(
        .W (odt_ctrl_pkg::PIN_COUNT)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_pins    ({i_a12, i_we_n, i_cas_n, i_ras_n, i_cs_n, i_cke, i_odt, i_ck}),
        .o_pins    (pins_s)
    );

    // Memory clock edges found from the synchronised copy
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ck_q      <= 1'b0;
            ck_rise_q <= 1'b0;
        end else begin
            ck_q      <= pins_s[odt_ctrl_pkg::PIN_CK];
            // Window logic steps one cycle late so it reads the tap after the shift lands
            ck_rise_q <= ck_rise;
        end
    end

    assign ck_rise = pins_s[odt_ctrl_pkg::PIN_CK] & ~ck_q;

    assign odt_mode_en = (|i_rtt_nom_bits) | (|i_rtt_wr_bits);
    assign dynamic_en  = |i_rtt_wr_bits;

    // Async mode in slow-exit power-down is not served: termination held off there
    assign active = i_dll_locked & ~i_dll_off_mode & ~i_self_refresh
                  & (pins_s[odt_ctrl_pkg::PIN_CKE] | i_any_bank_open
                     | i_mr0_dll_pd_keep);

    // Write latency carries the additive latency, so posting is built in
    assign write_lat = {1'b0, i_cas_write_lat} + {1'b0, i_additive_lat};
    assign term_lat  = IDX_W'(write_lat - 5'(odt_ctrl_pkg::LAT_OFFSET));

    assign odt_in = pins_s[odt_ctrl_pkg::PIN_ODT] & active & odt_mode_en;
    assign wr_in  = {burst_is_bl8(i_burst_mode, pins_s[odt_ctrl_pkg::PIN_A12]),
                     is_write_cmd({pins_s[odt_ctrl_pkg::PIN_CS_N],
                                   pins_s[odt_ctrl_pkg::PIN_RAS_N],
                                   pins_s[odt_ctrl_pkg::PIN_CAS_N],
                                   pins_s[odt_ctrl_pkg::PIN_WE_N]})
                     & active & dynamic_en};

    ck_delay_line #(
        .DEPTH (DEPTH),
        .W     (1)
    ) u_odt_line (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_shift   (ck_rise),
        .i_din     (odt_in),
        .i_tap     (term_lat),
        .o_dout    (odt_tap)
    );

    ck_delay_line #(
        .DEPTH (DEPTH),
        .W     (2)
    ) u_write_line (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_shift   (ck_rise),
        .i_din     (wr_in),
        .i_tap     (term_lat),
        .o_dout    (wr_tap)
    );

    // On at once when the delayed ODT rises, off half a clock after it falls
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            term_on <= 1'b0;
            off_cnt <= 3'h0;
        end else if (odt_tap) begin
            term_on <= 1'b1;
            off_cnt <= 3'h0;
        end else if (term_on) begin
            if (off_cnt == 3'(HALF - 1)) begin
                term_on <= 1'b0;
                off_cnt <= 3'h0;
            end else begin
                off_cnt <= off_cnt + 3'h1;
            end
        end
    end

    // Write window counted in memory clocks; a newer write reloads it
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_win  <= 1'b0;
            wr_left <= 3'h0;
        end else if (!dynamic_en) begin
            wr_win  <= 1'b0;
            wr_left <= 3'h0;
        end else if (ck_rise_q) begin
            if (wr_tap[0]) begin
                wr_win  <= 1'b1;
                wr_left <= wr_tap[1] ? 3'(odt_ctrl_pkg::WIN_BL8)
                                     : 3'(odt_ctrl_pkg::WIN_BC4);
            end else if (wr_win) begin
                if (wr_left == 3'h1) begin
                    wr_win <= 1'b0;
                end
                wr_left <= wr_left - 3'h1;
            end
        end
    end

    // Strength follows the window with half a clock of skew either way
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_term_is_write <= 1'b0;
            sw_cnt          <= 3'h0;
        end else if (!dynamic_en) begin
            o_term_is_write <= 1'b0;
            sw_cnt          <= 3'h0;
        end else if (wr_win != o_term_is_write) begin
            if (sw_cnt == 3'(HALF - 1)) begin
                o_term_is_write <= wr_win;
                sw_cnt          <= 3'h0;
            end else begin
                sw_cnt <= sw_cnt + 3'h1;
            end
        end else begin
            sw_cnt <= 3'h0;
        end
    end

    // Gates act at once so the pads never terminate while driving or in self-refresh
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_term_en   <= 1'b0;
            o_term_code <= 3'h0;
            o_sync_mode <= 1'b0;
        end else begin
            o_term_en   <= term_on & active & odt_mode_en & ~i_dq_driving
                         & (o_term_is_write | (|i_rtt_nom_bits));
            o_term_code <= o_term_is_write ? {1'b0, i_rtt_wr_bits}
                                           : i_rtt_nom_bits;
            o_sync_mode <= active;
        end
    end

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    sequence half_lag_high_s(sig);
        sig [*4];
    endsequence

    sequence half_lag_low_s(sig);
        !sig [*4];
    endsequence

    term_turn_on_a: assert property ($rose(odt_tap) |=> term_on)
        else $error("termination did not turn on with delayed ODT");

    term_turn_off_a: assert property (
        $fell(term_on) |-> (!odt_tap && !$past(odt_tap, 4)))
        else $error("termination turned off early after delayed ODT low");

    term_off_lag_a: assert property (
        $fell(odt_tap) |-> half_lag_high_s(term_on) ##1 (!term_on || odt_tap))
        else $error("termination off not half a clock after ODT low");

    self_refresh_off_a: assert property (i_self_refresh |=> !o_term_en)
        else $error("termination on during self-refresh");

    driving_off_a: assert property (i_dq_driving |=> !o_term_en)
        else $error("termination on while driving data bus");

    bits_zero_off_a: assert property (!odt_mode_en |=> !o_term_en)
        else $error("termination on with all termination bits zero");

    wr_switch_lag_a: assert property (
        ($rose(wr_win) && dynamic_en) |-> half_lag_low_s(o_term_is_write)
            ##1 (o_term_is_write || !dynamic_en || !wr_win))
        else $error("write strength not selected half a clock after switch");

    no_dynamic_a: assert property (!dynamic_en |=> !o_term_is_write)
        else $error("write strength selected with dynamic mode off");

    wr_window_len_a: assert property (
        (ck_rise_q && wr_tap[0] && dynamic_en) |=>
            wr_win && wr_left == ($past(wr_tap[1]) ? 3'h6 : 3'h4))
        else $error("write window not loaded with burst length");

    code_select_a: assert property (
        (o_term_is_write && $stable(i_rtt_wr_bits)) |=>
            o_term_code == {1'b0, $past(i_rtt_wr_bits)})
        else $error("write strength code not taken from MR2 bits");

    strength_back_a: assert property (
        ($fell(wr_win) && dynamic_en) |-> half_lag_high_s(o_term_is_write)
            ##1 (!o_term_is_write || wr_win || !dynamic_en))
        else $error("nominal strength not restored half a clock after window");

    window_close_a: assert property (
        (ck_rise_q && wr_win && !wr_tap[0] && wr_left == 3'h1 && dynamic_en)
            |=> !wr_win)
        else $error("write window outlived its burst length");

    code_nom_a: assert property (
        (!o_term_is_write && $stable(i_rtt_nom_bits)) |=>
            o_term_code == $past(i_rtt_nom_bits))
        else $error("nominal strength code not taken from MR1 bits");

    sync_mode_a: assert property ((i_dll_off_mode || i_self_refresh) |=> !o_sync_mode)
        else $error("synchronous mode reported with DLL off or in self-refresh");

endmodule : odt_sync_ctrl

`default_nettype wire

// >>> design/odt_ctrl_pkg.sv
package odt_ctrl_pkg;

    // Clocking of the bench: system clock and memory clock periods
    localparam int SYS_PERIOD_NS  = 10;
    localparam int CK_PERIOD_NS   = 80;
    // Nominal turn-off delay and strength-change skew, half a memory clock
    localparam int HALF_CK_NS     = CK_PERIOD_NS / 2;
    localparam int HALF_CK_CYCLES = (HALF_CK_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // Termination latency is write latency less this many memory clocks
    localparam int LAT_OFFSET     = 2;
    // Write-termination window beyond the switch, in memory clocks
    localparam int WIN_BC4        = 4;
    localparam int WIN_BL8        = 6;

    // Depth and index width of the memory-clock delay lines
    localparam int LINE_DEPTH     = 32;
    localparam int LINE_IDX_W     = 5;

    // Burst length field of MR0 bits A1:A0
    localparam logic [1:0] BL_FIXED_8 = 2'h0;
    localparam logic [1:0] BL_OTF     = 2'h1;
    localparam logic [1:0] BL_FIXED_4 = 2'h2;

    // Synchronised pin bundle bit positions
    localparam int PIN_CK     = 0;
    localparam int PIN_ODT    = 1;
    localparam int PIN_CKE    = 2;
    localparam int PIN_CS_N   = 3;
    localparam int PIN_RAS_N  = 4;
    localparam int PIN_CAS_N  = 5;
    localparam int PIN_WE_N   = 6;
    localparam int PIN_A12    = 7;
    localparam int PIN_COUNT  = 8;

    // Write command code on {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_WRITE = 4'h4;

endpackage : odt_ctrl_pkg

// >>> design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_arst_n,
    // Pins
    input  wire logic [W-1:0] i_pins,
    output logic      [W-1:0] o_pins
);

    logic [W-1:0] meta;

    initial begin
        if (W < 1) $error("pin_sync width must be at least one");
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta   <= '0;
            o_pins <= '0;
        end else begin
            meta   <= i_pins;
            o_pins <= meta;
        end
    end

endmodule : pin_sync

`default_nettype wire

// >>> design/ck_delay_line.sv
`timescale 1ns/1ps
`default_nettype none

module ck_delay_line #(
    parameter int DEPTH = 32,
    parameter int W     = 1
) (
    // Clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_arst_n,
    // Shift on each memory clock rising edge
    input  wire logic                     i_shift,
    input  wire logic [W-1:0]             i_din,
    input  wire logic [$clog2(DEPTH)-1:0] i_tap,
    output logic      [W-1:0]             o_dout
);

    logic [W-1:0] stage [DEPTH];

    initial begin
        if (DEPTH < 2) $error("ck_delay_line depth must be at least two");
    end

    // Stage n holds the sample taken n memory clocks ago
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < DEPTH; i++) stage[i] <= '0;
        end else if (i_shift) begin
            stage[0] <= i_din;
            for (int i = 1; i < DEPTH; i++) stage[i] <= stage[i-1];
        end
    end

    assign o_dout = stage[i_tap];

endmodule : ck_delay_line

`default_nettype wire

// >>> sim/ddr3_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module ddr3_ctrl_model (
    // Memory pins driven by the controller
    output logic o_ck,
    output logic o_odt,
    output logic o_cke,
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic o_a12
);
    int   hold;
    logic odt_q;
    logic wr_bl8;
    logic busy;

    // Memory clock runs free, offset so it never lines up with the system clock
    initial begin
        {o_ck, o_odt, odt_q, busy, wr_bl8} = 5'h0;
        {o_ras_n, o_cas_n, o_we_n, o_a12} = 4'h0;
        {o_cke, o_cs_n} = 2'h3;
        hold = 0;
        #3;
        forever #(odt_ctrl_pkg::CK_PERIOD_NS / 2) o_ck = ~o_ck;
    end

    // Deselected lines keep changing so a stale value never looks valid
    always @(negedge o_ck) begin
        if (!busy) begin
            o_cs_n <= 1'b1;
            {o_ras_n, o_cas_n, o_we_n, o_a12} <= ~{o_ras_n, o_cas_n, o_we_n, o_a12};
        end
    end

    // Minimum ODT high time, counted in registered memory clocks
    always @(posedge o_ck) begin
        odt_q <= o_odt;
        if (o_odt && !o_cs_n && o_ras_n && !o_cas_n && !o_we_n)
            hold <= wr_bl8 ? 6 : 4;
        else if (o_odt && !odt_q)
            hold <= 4;
        else if (hold > 0)
            hold <= hold - 1;
    end

    task automatic set_odt(input logic v, output time t);
        @(negedge o_ck);
        while (!v && hold > 1) @(negedge o_ck);
        o_odt <= v;
        @(posedge o_ck) t = $time;
    endtask : set_odt

    task automatic set_cke(input logic v);
        @(negedge o_ck) o_cke <= v;
    endtask : set_cke

    task automatic write(input logic a12v, input logic bl8, output time t);
        @(negedge o_ck);
        busy   = 1'b1;
        wr_bl8 = bl8;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_a12} <= {odt_ctrl_pkg::CMD_WRITE, a12v};
        @(posedge o_ck) t = $time;
        @(negedge o_ck);
        o_cs_n <= 1'b1;
        busy   = 1'b0;
    endtask : write

    task automatic wait_ck(input int n);
        repeat (n) @(posedge o_ck);
    endtask : wait_ck
endmodule : ddr3_ctrl_model

`default_nettype wire

// >>> sim/ddr3_odt_sync_dynamic_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module ddr3_odt_sync_dynamic_tb;
    localparam int CK   = odt_ctrl_pkg::CK_PERIOD_NS;
    localparam int HALF = odt_ctrl_pkg::HALF_CK_NS;

    logic       sys_clk = 1'b0;
    logic       arst_n;
    logic [3:0] cwl;
    logic [3:0] al;
    logic [2:0] nom;
    logic [1:0] wr;
    logic [1:0] bm;
    logic       keep, locked, dll_off, sref, bank, dq;
    wire        ck, odt, cke, cs_n, ras_n, cas_n, we_n, a12;
    logic       term_en, is_wr, sync;
    logic [2:0] code;
    int         bad_count, tests_run, cycles, n, lat;
    time        t0, t1;

    always #(odt_ctrl_pkg::SYS_PERIOD_NS / 2) sys_clk = ~sys_clk;

    ddr3_ctrl_model i_ctrl (.o_ck(ck), .o_odt(odt), .o_cke(cke), .o_cs_n(cs_n),
        .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_a12(a12));

    odt_sync_ctrl i_dut (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_ck(ck), .i_odt(odt),
        .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_a12(a12), .i_cas_write_lat(cwl), .i_additive_lat(al), .i_rtt_nom_bits(nom),
        .i_rtt_wr_bits(wr), .i_burst_mode(bm), .i_mr0_dll_pd_keep(keep),
        .i_dll_locked(locked), .i_dll_off_mode(dll_off), .i_self_refresh(sref),
        .i_any_bank_open(bank), .i_dq_driving(dq), .o_term_en(term_en),
        .o_term_is_write(is_wr), .o_term_code(code), .o_sync_mode(sync));

    task automatic conclude();
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Whole run is a few thousand cycles; this only catches a hang
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            conclude();
        end
    end

    function automatic logic flag(input int s);
        return s ? is_wr : term_en;
    endfunction : flag

    // Delay from a sampling CK edge to an output change, in whole memory clocks
    task automatic meas(input int s, input logic lvl, input time t, input int extra,
                        output int k);
        int i;
        i = 0;
        while (flag(s) !== lvl && i < 4000) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        k = (int'($time - t) - extra) / CK;
    endtask : meas

    task automatic cfg(input int c, input int a, input logic [2:0] rn, input logic [1:0] rw,
                       input logic [1:0] b);
        @(posedge sys_clk);
        cwl <= 4'(c);
        al  <= 4'(a);
        nom <= rn;
        wr  <= rw;
        bm  <= b;
        lat = c + a - 2;
        repeat (4) @(posedge sys_clk);
    endtask : cfg

    task automatic t_nominal(input int c, input int a);
        cfg(c, a, 3'h5, 2'h0, odt_ctrl_pkg::BL_FIXED_8);
        i_ctrl.set_odt(1'b1, t0);
        meas(0, 1'b1, t0, 0, n);
        `CHK(n, lat)
        `CHK(code, 3'h5)
        `CHK(sync, 1'b1)
        `CHK(is_wr, 1'b0)
        i_ctrl.set_odt(1'b0, t0);
        meas(0, 1'b0, t0, HALF, n);
        `CHK(n, lat)
        @(posedge sys_clk);
        dq <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(term_en, 1'b0)
        @(posedge sys_clk);
        dq <= 1'b0;
        i_ctrl.wait_ck(4);
    endtask : t_nominal

    task automatic t_write(input logic [1:0] b, input logic a12v, input logic bl8);
        cfg(6, 1, 3'h1, 2'h2, b);
        i_ctrl.set_odt(1'b1, t0);
        i_ctrl.write(a12v, bl8, t0);
        meas(1, 1'b1, t0, HALF, n);
        `CHK(n, lat)
        @(posedge sys_clk);
        #1;
        `CHK(code, 3'h2)
        meas(1, 1'b0, t0, HALF, n);
        `CHK(n, lat + (bl8 ? 6 : 4))
        i_ctrl.set_odt(1'b0, t1);
        i_ctrl.wait_ck(lat + 4);
    endtask : t_write

    task automatic t_restart();
        cfg(5, 0, 3'h1, 2'h1, odt_ctrl_pkg::BL_FIXED_8);
        i_ctrl.set_odt(1'b1, t0);
        i_ctrl.write(1'b1, 1'b1, t0);
        i_ctrl.write(1'b1, 1'b1, t1);
        meas(1, 1'b1, t0, HALF, n);
        `CHK(n, lat)
        meas(1, 1'b0, t1, HALF, n);
        `CHK(n, lat + 6)
        i_ctrl.set_odt(1'b0, t1);
        i_ctrl.wait_ck(lat + 4);
    endtask : t_restart

    // DLL-off keeps nominal bits zero; case 5 overlaps a read with ODT high on purpose
    task automatic t_gate(input int k);
        cfg(5, 0, (k == 0 || k == 2) ? 3'h0 : 3'h3, 2'h0, odt_ctrl_pkg::BL_FIXED_8);
        sref    <= (k == 1);
        dll_off <= (k == 2);
        locked  <= (k != 2);
        keep    <= (k == 4);
        bank    <= (k == 5);
        i_ctrl.set_cke(k < 3);
        i_ctrl.set_odt(1'b1, t0);
        i_ctrl.wait_ck(lat + 2);
        `CHK(term_en, k > 3)
        if (k > 1) `CHK(sync, k > 3)
        if (k == 5) begin
            @(posedge sys_clk);
            dq <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
            `CHK(term_en, 1'b0)
            @(posedge sys_clk);
            dq <= 1'b0;
        end
        i_ctrl.set_odt(1'b0, t1);
        @(posedge sys_clk);
        {sref, dll_off, locked, keep, bank} <= 5'h04;
        i_ctrl.set_cke(1'b1);
        i_ctrl.wait_ck(lat + 4);
    endtask : t_gate

    initial begin
        arst_n = 1'b0;
        {cwl, al, nom, wr, bm} = {4'h5, 4'h0, 3'h0, 2'h0, 2'h0};
        {keep, locked, dll_off, sref, bank, dq} = 6'h10;
        {bad_count, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_nominal(5, 0);
        t_nominal(6, 3);
        t_write(odt_ctrl_pkg::BL_FIXED_8, 1'b0, 1'b1);
        t_write(odt_ctrl_pkg::BL_FIXED_4, 1'b1, 1'b0);
        t_write(odt_ctrl_pkg::BL_OTF, 1'b1, 1'b1);
        t_write(odt_ctrl_pkg::BL_OTF, 1'b0, 1'b0);
        t_restart();
        for (int k = 0; k < 6; k++) t_gate(k);
        conclude();
    end
endmodule : ddr3_odt_sync_dynamic_tb

`default_nettype wire
